// >>> retimer_regs_map.svh
// register offsets, field positions, reset values and timing counts
// included by the package and the register bank; definitions only
`ifndef RETIMER_REGS_MAP_SVH
`define RETIMER_REGS_MAP_SVH

// register indices; byte address is four times the index
`define IDX_CONTENTION        6'h0D
`define IDX_SWING_PRE         6'h0E
`define IDX_TIMEOUT_LOW       6'h10
`define IDX_TIMEOUT_HIGH      6'h11
`define IDX_IRQ_STATUS        6'h14
`define IDX_IRQ_CLEAR         6'h15
`define IDX_IRQ_ENABLE        6'h16

// contention flag positions
`define BIT_OUT_NEG           5
`define BIT_OUT_POS           4
`define BIT_IN_NEG            1
`define BIT_IN_POS            0

// swing and pre-emphasis field positions
`define SWING_HI              5
`define SWING_LO              4
`define PRE_HI                1
`define PRE_LO                0

// field codes
`define CODE_SWING_200        2'h1
`define CODE_SWING_220        2'h2
`define CODE_PRE_0DB          2'h1
`define CODE_PRE_2P5DB        2'h2

// three-level pin encoding after the level comparators
`define PIN_LOW               2'h0
`define PIN_MID               2'h1
`define PIN_HIGH              2'h2

// reset values
`define RST_TIMEOUT_BYTE      8'hFF
`define RST_FIELD             2'h0

// interrupt event positions
`define EV_TIMEOUT            0
`define EV_ACK                1
`define EV_CONTENTION         2
`define EV_WIDTH              3

// cycles the pin synchroniser needs before pins are captured
`define CFG_SETTLE_CYCLES     2'h3

`endif

// >>> retimer_regs_pkg.sv
// types for the re-timer status and turnaround register bank
// assumes retimer_regs_map.svh holds the register and field constants
`include "retimer_regs_map.svh"

package retimer_regs_pkg;

    // turnaround timer state, one-hot
    typedef enum logic [1:0]
    {
        TA_IDLE = 2'b01,
        TA_WAIT = 2'b10
    } ta_state_t;

    typedef logic [7:0] reg_byte_t;

endpackage : retimer_regs_pkg

// >>> retimer_status_bta_regs.sv
// status, swing/pre-emphasis and turnaround timeout registers on APB
// assumes pins, the low-power clock and lane detectors are asynchronous
// to clk_sys_i; each passes two flip-flops before use
//
// Functional notes
// - four lane-0 contention flags, read-only, 1 means seen, reset to 0.
// - flags at bits 5,4,1,0; bits 7:6 and 3:2 reserved read-only.
// - swing field bits 5:4: 00 180mV, 01 200mV, 1x 220mV.
// - swing loaded from config pins at reset per pin-level table.
// - pre-emphasis bits 1:0: 00 1.5dB, 01 0dB, 1x 2.5dB.
// - pre-emphasis loaded from second pin: mid/low gives 01, high 2.5dB.
// - software may overwrite both pin-loaded fields; written values then used.
// - 16-bit timeout, low byte turnaround_timeout_low, high byte turnaround_timeout_high, both reset 0xFF.
// - turnaround request restarts timer; acknowledge stops it.
// - timer expiry before acknowledge abandons the turnaround.
// - timeout counter advances on low-power transmit clock edges only.
// - back-channel turnaround handled only on data lane 0.
// - pairs pass with polarity unchanged; no swap option exists.
// - camera use allows any data-lane assignment and subsets.
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`include "retimer_regs_map.svh"

module retimer_status_bta_regs
(
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // low-power transmit clock of lane 0
    input  wire logic        lp_tx_clk_i,
    // lane-0 turnaround request and acknowledge, levels
    input  wire logic        bta_req_i,
    input  wire logic        bta_ack_i,
    // lane-0 contention detectors, levels
    input  wire logic        in_lane0_pos_cd_i,
    input  wire logic        in_lane0_neg_cd_i,
    input  wire logic        out_lane0_pos_cd_i,
    input  wire logic        out_lane0_neg_cd_i,
    // three-level config pins, comparator code
    input  wire logic [1:0]  config_pin_a_i,
    input  wire logic [1:0]  config_pin_b_i,
    // analog controls
    output logic      [1:0]  hs_swing_level_o,
    output logic      [1:0]  hs_preemphasis_level_o,
    // turnaround status
    output logic             bta_active_o,
    output logic             bta_abort_o,
    output logic             irq_o
);

    localparam int SYNC_W = 11;

    // reset synchroniser
    logic                    rst_meta_r;
    logic                    rst_n;

    // input synchroniser
    logic [SYNC_W-1:0]       sync_meta_r;
    logic [SYNC_W-1:0]       sync_r;

    // synchronised views
    logic                    lp_clk_s;
    logic                    req_s;
    logic                    ack_s;
    logic [3:0]              cd_s;
    logic [1:0]              pin_a_s;
    logic [1:0]              pin_b_s;

    // edge detection
    logic                    lp_clk_d_r;
    logic                    req_d_r;
    logic                    lp_edge;
    logic                    req_rise;

    // registers
    logic [3:0]              cont_r;
    logic [1:0]              swing_r;
    logic [1:0]              pre_r;
    retimer_regs_pkg::reg_byte_t tmo_lo_r;
    retimer_regs_pkg::reg_byte_t tmo_hi_r;
    logic [`EV_WIDTH-1:0]    irq_stat_r;
    logic [`EV_WIDTH-1:0]    irq_en_r;

    // config capture
    logic [1:0]              settle_r;
    logic                    cfg_done_r;
    logic [1:0]              swing_pin;
    logic [1:0]              pre_pin;

    // turnaround timer and interrupt events
    retimer_regs_pkg::ta_state_t ta_state_r;
    logic [15:0]             ta_cnt_r;
    logic [15:0]             tmo_value;
    logic                    ev_timeout;
    logic                    ev_ack;
    logic                    ev_cont;

    // bus decode
    logic                    acc;
    logic                    wr;
    logic                    aligned;
    logic [5:0]              idx;
    logic                    mapped;
    logic [7:0]              rd_byte;

    // reset release through two flip-flops
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // two-flop synchroniser for every asynchronous input
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_meta_r <= '0;
            sync_r      <= '0;
        end
        else
        begin
            sync_meta_r <= {lp_tx_clk_i, bta_req_i, bta_ack_i,
                            out_lane0_neg_cd_i, out_lane0_pos_cd_i,
                            in_lane0_neg_cd_i, in_lane0_pos_cd_i,
                            config_pin_a_i, config_pin_b_i};
            sync_r      <= sync_meta_r;
        end
    end

    assign lp_clk_s = sync_r[10];
    assign req_s    = sync_r[9];
    assign ack_s    = sync_r[8];
    assign cd_s     = sync_r[7:4]; // out neg, out pos, in neg, in pos
    assign pin_a_s  = sync_r[3:2];
    assign pin_b_s  = sync_r[1:0];

    // edge finders on the synchronised copies
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lp_clk_d_r <= 1'b0;
            req_d_r    <= 1'b0;
        end
        else
        begin
            lp_clk_d_r <= lp_clk_s;
            req_d_r    <= req_s;
        end
    end

    assign lp_edge  = lp_clk_s & ~lp_clk_d_r;
    assign req_rise = req_s & ~req_d_r;

    assign swing_pin = (pin_a_s == `PIN_HIGH || (pin_a_s == `PIN_LOW && pin_b_s == `PIN_HIGH)) ?
                       `CODE_SWING_220 : `CODE_SWING_200;

    assign pre_pin = (pin_b_s == `PIN_HIGH) ? `CODE_PRE_2P5DB : `CODE_PRE_0DB;

    // capture once the synchroniser holds post-release pin levels
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            settle_r   <= 2'h0;
            cfg_done_r <= 1'b0;
        end
        else if (!cfg_done_r)
        begin
            if (settle_r == `CFG_SETTLE_CYCLES)
                cfg_done_r <= 1'b1;
            else
                settle_r <= settle_r + 2'h1;
        end
    end

    // apb decode, zero wait states
    assign acc     = psel_i & penable_i;
    assign wr      = acc & pwrite_i;
    assign idx     = paddr_i[7:2];
    assign aligned = (paddr_i[1:0] == 2'h0);
    assign mapped  = aligned && (idx == `IDX_CONTENTION || idx == `IDX_SWING_PRE ||
                                 idx == `IDX_TIMEOUT_LOW || idx == `IDX_TIMEOUT_HIGH ||
                                 idx == `IDX_IRQ_STATUS || idx == `IDX_IRQ_CLEAR ||
                                 idx == `IDX_IRQ_ENABLE);
    assign pready_o  = 1'b1;
    assign pslverr_o = acc & ~mapped; // unmapped address answers with error

    // contention flags track the lane-0 detectors
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            cont_r <= 4'h0;
        else
            cont_r <= cd_s;
    end

    // new contention on any wire is an interrupt event
    assign ev_cont = |(cd_s & ~cont_r);

    // swing and pre-emphasis, pin load then software writes
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            swing_r <= `RST_FIELD;
            pre_r   <= `RST_FIELD;
        end
        else if (!cfg_done_r && settle_r == `CFG_SETTLE_CYCLES)
        begin
            swing_r <= swing_pin;
            pre_r   <= pre_pin;
        end
        else if (wr && aligned && idx == `IDX_SWING_PRE)
        begin
            swing_r <= pwdata_i[`SWING_HI:`SWING_LO];
            pre_r   <= pwdata_i[`PRE_HI:`PRE_LO];
        end
    end

    assign hs_swing_level_o       = swing_r;
    assign hs_preemphasis_level_o = pre_r;

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tmo_lo_r <= `RST_TIMEOUT_BYTE;
            tmo_hi_r <= `RST_TIMEOUT_BYTE;
        end
        else if (wr && aligned)
        begin
            if (idx == `IDX_TIMEOUT_LOW)
                tmo_lo_r <= pwdata_i[7:0];
            if (idx == `IDX_TIMEOUT_HIGH)
                tmo_hi_r <= pwdata_i[7:0];
        end
    end

    assign tmo_value = {tmo_hi_r, tmo_lo_r};

    // only lane 0 runs a turnaround; other lanes are forward-only
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ta_state_r <= retimer_regs_pkg::TA_IDLE;
            ta_cnt_r   <= 16'h0000;
        end
        else if (req_rise)
        begin
            ta_state_r <= retimer_regs_pkg::TA_WAIT;
            ta_cnt_r   <= 16'h0000;
        end
        else
        begin
            case (ta_state_r)
                retimer_regs_pkg::TA_IDLE: ta_cnt_r <= ta_cnt_r;
                retimer_regs_pkg::TA_WAIT:
                begin
                    if (lp_edge)
                    begin
                        if (ack_s)
                            ta_state_r <= retimer_regs_pkg::TA_IDLE;
                        else if (ta_cnt_r == tmo_value)
                            ta_state_r <= retimer_regs_pkg::TA_IDLE;
                        else
                            ta_cnt_r <= ta_cnt_r + 16'h0001;
                    end
                end
                default: ta_state_r <= retimer_regs_pkg::TA_IDLE;
            endcase
        end
    end

    // timer outcome events
    assign ev_ack     = ~req_rise && ta_state_r == retimer_regs_pkg::TA_WAIT && lp_edge && ack_s;
    assign ev_timeout = ~req_rise && ta_state_r == retimer_regs_pkg::TA_WAIT && lp_edge &&
                        ~ack_s && ta_cnt_r == tmo_value;

    // abort pulse to the lane-0 turnaround logic
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            bta_abort_o <= 1'b0;
        else
            bta_abort_o <= ev_timeout;
    end

    assign bta_active_o = (ta_state_r == retimer_regs_pkg::TA_WAIT);

    // sticky interrupt status; a new event wins over a clear
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            irq_stat_r <= '0;
        else
        begin
            for (int i = 0; i < `EV_WIDTH; i++)
            begin
                if (wr && aligned && idx == `IDX_IRQ_CLEAR && pwdata_i[i])
                    irq_stat_r[i] <= 1'b0;
            end
            if (ev_timeout)
                irq_stat_r[`EV_TIMEOUT] <= 1'b1;
            if (ev_ack)
                irq_stat_r[`EV_ACK] <= 1'b1;
            if (ev_cont)
                irq_stat_r[`EV_CONTENTION] <= 1'b1;
        end
    end

    // interrupt enable
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            irq_en_r <= '0;
        else if (wr && aligned && idx == `IDX_IRQ_ENABLE)
            irq_en_r <= pwdata_i[`EV_WIDTH-1:0];
    end

    assign irq_o = |(irq_stat_r & irq_en_r);

    // read mux
    always_comb
    begin
        rd_byte = 8'h00;
        case (idx)
            `IDX_CONTENTION:
            begin
                rd_byte[`BIT_OUT_NEG] = cont_r[3];
                rd_byte[`BIT_OUT_POS] = cont_r[2];
                rd_byte[`BIT_IN_NEG]  = cont_r[1];
                rd_byte[`BIT_IN_POS]  = cont_r[0];
            end
            `IDX_SWING_PRE:
            begin
                rd_byte[`SWING_HI:`SWING_LO] = swing_r;
                rd_byte[`PRE_HI:`PRE_LO]     = pre_r;
            end
            `IDX_TIMEOUT_LOW:  rd_byte = tmo_lo_r;
            `IDX_TIMEOUT_HIGH: rd_byte = tmo_hi_r;
            `IDX_IRQ_STATUS:   rd_byte[`EV_WIDTH-1:0] = irq_stat_r;
            `IDX_IRQ_ENABLE:   rd_byte[`EV_WIDTH-1:0] = irq_en_r;
            default:           rd_byte = 8'h00;
        endcase
        if (!aligned)
            rd_byte = 8'h00;
    end

    // read data registered at the setup phase, valid in the access phase
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            prdata_o <= 32'h0000_0000;
        else if (psel_i && !penable_i && !pwrite_i)
            prdata_o <= {24'h00_0000, rd_byte};
    end

    // no polarity swap control exists in this bank
    // no lane-ordering constraint applies outside lane 0

endmodule : retimer_status_bta_regs

// >>> retimer_status_bta_regs_checker.sv
// port assertions for the retimer register bank
// assumes a link clock of eight to fourteen system clocks
`timescale 1ns/10ps

module retimer_status_bta_regs_checker
(
    input wire logic        clk_sys_i,
    input wire logic        nrst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        lp_tx_clk_i,
    input wire logic        bta_req_i,
    input wire logic        bta_ack_i,
    input wire logic        in_lane0_pos_cd_i,
    input wire logic        in_lane0_neg_cd_i,
    input wire logic        out_lane0_pos_cd_i,
    input wire logic        out_lane0_neg_cd_i,
    input wire logic [1:0]  config_pin_a_i,
    input wire logic [1:0]  config_pin_b_i,
    input wire logic [1:0]  hs_swing_level_o,
    input wire logic [1:0]  hs_preemphasis_level_o,
    input wire logic        bta_active_o,
    input wire logic        bta_abort_o,
    input wire logic        irq_o
);
    wire logic [3:0] cd_w;
    wire logic       rd_w;

    // detector levels in register order, and a read access phase
    assign cd_w = {out_lane0_neg_cd_i, out_lane0_pos_cd_i, in_lane0_neg_cd_i, in_lane0_pos_cd_i};
    assign rd_w = psel_i && penable_i && !pwrite_i;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    a_abort_single: assert property (bta_abort_o |=> !bta_abort_o)
        else $error("abort pulse too long");
    a_abort_after_wait: assert property (bta_abort_o |-> !bta_active_o && $past(bta_active_o, 2))
        else $error("abort without a wait before it");
    a_req_starts: assert property ($rose(bta_req_i) |-> ##[1:5] bta_active_o)
        else $error("request did not start the timer");
    a_wait_cause: assert property ($rose(bta_active_o) |-> $past(bta_req_i, 2))
        else $error("timer started without request");
    a_ack_stops: assert property (bta_active_o && bta_ack_i |-> ##[1:16] !bta_active_o)
        else $error("acknowledge did not stop timer");
    a_stop_on_lp: assert property ($fell(bta_active_o) |-> $past(lp_tx_clk_i, 3) || $past(lp_tx_clk_i, 4))
        else $error("timer stopped off a link clock edge");
    a_flags_live: assert property ($stable(cd_w) [*6] ##1 rd_w && paddr_i == 8'h34 |->
        prdata_o == {26'h0, cd_w[3:2], 2'h0, cd_w[1:0]}) else $error("contention flags wrong");
    a_cfg_read: assert property (rd_w && paddr_i == 8'h38 |->
        prdata_o == {26'h0, hs_swing_level_o, 2'h0, hs_preemphasis_level_o}) else $error("cfg read wrong");
    a_timeout_mapped: assert property (psel_i && penable_i && paddr_i == 8'h40 |-> pready_o && !pslverr_o)
        else $error("timeout byte refused");

    c_abort: cover property (bta_abort_o);
    c_ack_stop: cover property (bta_active_o && bta_ack_i ##[1:16] !bta_active_o);
    c_refused: cover property (pslverr_o);
endmodule : retimer_status_bta_regs_checker

bind retimer_status_bta_regs retimer_status_bta_regs_checker u_chk (.*);

// >>> lane0_far_model.sv
// lane-0 far side: turnaround requester with its low-power clock
// assumes the bench raises go_i for one frame and lowers it to end it
`timescale 1ns/10ps

module lane0_far_model
(
    input  wire logic       go_i,
    input  wire logic [8:0] ack_after_i,
    output logic            lp_clk_o,
    output logic            req_o,
    output logic            ack_o
);
    int n;

    // idle levels before the first frame
    initial {lp_clk_o, req_o, ack_o} = 3'h0;

    // lane-0 frame: request, then 200 ns clock until go falls, at most 399 cycles
    always @(posedge go_i)
    begin
        req_o = 1'b1;
        #7;
        for (n = 1; n < 400 && go_i; n++)
        begin
            #100 lp_clk_o = 1'b1;
            #100 lp_clk_o = 1'b0;
            ack_o = ack_o || (n == int'(ack_after_i));
        end
        wait (!go_i);
        req_o = 1'b0;
        ack_o = 1'b0;
    end
endmodule : lane0_far_model

// >>> retimer_status_bta_regs_tb.sv
// self-checking bench for the retimer status and turnaround registers
// assumes the lane-0 far-side model and the bound port checker
`timescale 1ns/10ps

module retimer_status_bta_regs_tb;
    logic             clk_sys_i = 1'b0, nrst_i = 1'b0, go = 1'b0;
    logic             psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]       paddr_i = 8'h00;
    logic [31:0]      pwdata_i = 32'h0;
    logic [3:0]       cd = 4'h0;
    logic [1:0]       config_pin_a_i = 2'h1, config_pin_b_i = 2'h0;
    logic [8:0]       ack_after = 9'h0;
    wire logic        lp_tx_clk_i, bta_req_i, bta_ack_i, pready_o, pslverr_o;
    wire logic        in_lane0_pos_cd_i, in_lane0_neg_cd_i, out_lane0_pos_cd_i, out_lane0_neg_cd_i;
    wire logic        bta_active_o, bta_abort_o, irq_o;
    wire logic [1:0]  hs_swing_level_o, hs_preemphasis_level_o;
    wire logic [31:0] prdata_o;
    int               mismatches = 0, checked = 0, lp_cnt = 0;

    // system clock, 25 ns period
    always #12.5 clk_sys_i = ~clk_sys_i;

    // link clock edges counted by the bench
    always @(posedge lp_tx_clk_i) lp_cnt++;

    // detector levels in register bit order
    assign {out_lane0_neg_cd_i, out_lane0_pos_cd_i, in_lane0_neg_cd_i, in_lane0_pos_cd_i} = cd;

    retimer_status_bta_regs DUT (.*);

    lane0_far_model far (.go_i(go), .ack_after_i(ack_after), .lp_clk_o(lp_tx_clk_i), .req_o(bta_req_i), .ack_o(bta_ack_i));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask : chk

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk_sys_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        @(posedge clk_sys_i);
        // only the watchdog ends a wait for the answer
        while (pready_o !== 1'b1)
            @(posedge clk_sys_i);
        q = prdata_o;
        e = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, {24'h0, d}, q, e);
    endtask : wr

    // read, compare data and error flag
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(n, x, q);
        chk({n, "_err"}, {31'h0, a == 8'h3C || a == 8'h41}, {31'h0, e});
    endtask : rd

    task automatic do_reset(input logic [1:0] a, input logic [1:0] b);
        @(posedge clk_sys_i);
        {nrst_i, config_pin_a_i, config_pin_b_i} <= {1'b0, a, b};
        repeat (3) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (12) @(posedge clk_sys_i);
    endtask : do_reset

    // live flags, sticky event, masked and cleared interrupt
    task automatic t_cont;
        for (int i = 0; i < 5; i++)
        begin
            cd <= (i < 4) ? 4'(1 << i) : 4'hF;
            wr(8'h58, (i < 4) ? 8'h04 : 8'h00);
            repeat (4) @(posedge clk_sys_i);
            wr(8'h34, 8'hFF);
            rd("flags", 8'h34, {26'h0, cd[3:2], 2'h0, cd[1:0]});
            chk("irq", {31'h0, i < 4}, {31'h0, irq_o});
            rd("status", 8'h50, 32'h4);
            cd <= 4'h0;
            wr(8'h54, 8'h04);
            rd("cleared", 8'h50, 32'h0);
        end
        $display("contention test done");
    endtask : t_cont

    // every swing and pre-emphasis code, reserved bits, bad addresses
    task automatic t_fields;
        logic [7:0] v;
        for (int c = 0; c < 4; c++)
        begin
            v = 8'(c * 17) ^ 8'h03;
            wr(8'h38, v | 8'hCC);
            rd("cfg", 8'h38, {24'h0, v});
            chk("swing", {30'h0, v[5:4]}, {30'h0, hs_swing_level_o});
            chk("pre", {30'h0, v[1:0]}, {30'h0, hs_preemphasis_level_o});
        end
        wr(8'h3C, 8'h55);
        rd("unmapped", 8'h3C, 32'h0);
        rd("misaligned", 8'h41, 32'h0);
        $display("field test done");
    endtask : t_fields

    // expiry after value plus one link edges, abort and interrupt
    task automatic t_bta(input logic [15:0] v);
        wr(8'h58, 8'h01);
        wr(8'h40, v[7:0]);
        wr(8'h44, v[15:8]);
        rd("tmo_low", 8'h40, {24'h0, v[7:0]});
        rd("tmo_high", 8'h44, {24'h0, v[15:8]});
        lp_cnt = 0;
        go <= 1'b1;
        while (bta_abort_o !== 1'b1)
            @(posedge clk_sys_i);
        chk("lp_edges", 32'(v) + 32'h1, 32'(lp_cnt));
        @(posedge clk_sys_i);
        chk("active", 32'h0, {31'h0, bta_active_o});
        chk("irq", 32'h1, {31'h0, irq_o});
        go <= 1'b0;
        wr(8'h54, 8'h01);
        rd("status", 8'h50, 32'h0);
        $display("timeout test done");
    endtask : t_bta

    // acknowledge before expiry stops the timer with no abort
    task automatic t_ack;
        logic ab;
        ab = 1'b0;
        wr(8'h58, 8'h02);
        ack_after <= 9'h2;
        go <= 1'b1;
        for (int t = 0; t < 200; t++)
        begin
            @(posedge clk_sys_i);
            ab = ab | bta_abort_o;
            if (t == 10)
                chk("waiting", 32'h1, {31'h0, bta_active_o});
        end
        chk("abort", 32'h0, {31'h0, ab});
        chk("stopped", 32'h0, {31'h0, bta_active_o});
        chk("irq", 32'h1, {31'h0, irq_o});
        {go, ack_after} <= 10'h0;
        wr(8'h54, 8'h02);
        $display("acknowledge test done");
    endtask : t_ack

    // pin-loaded fields and reset values for four pin combinations
    task automatic t_pins;
        logic [11:0] tab [4] = '{12'h011, 12'h222, 12'h921, 12'h612};
        for (int i = 0; i < 4; i++)
        begin
            do_reset(tab[i][11:10], tab[i][9:8]);
            rd("cfg", 8'h38, {24'h0, tab[i][7:0]});
            rd("tmo_low", 8'h40, 32'hFF);
            rd("tmo_high", 8'h44, 32'hFF);
            rd("flags", 8'h34, 32'h0);
        end
        $display("pin test done");
    endtask : t_pins

    task automatic test_done;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // main sequence
    initial
    begin
        do_reset(2'h1, 2'h0);
        t_cont;
        t_fields;
        t_bta(16'h0102);
        t_bta(16'h0003);
        t_ack;
        t_pins;
        test_done;
    end

    // watchdog, far beyond the run's well under a hundred microseconds
    initial
    begin
        #2000000;
        mismatches++;
        test_done;
    end
endmodule : retimer_status_bta_regs_tb
